// ===== coeff_pkg.sv
// Constants and carrier types for the loop-filter coefficient decoder.
// Assumes a 32-bit APB register bus and a 25 MHz system clock.
package coeff_pkg;

  // Byte offsets of the register map.
  localparam logic [7:0] off_alpha_mant = 8'h00;
  localparam logic [7:0] off_alpha_exp = 8'h04;
  localparam logic [7:0] off_beta_mant = 8'h08;
  localparam logic [7:0] off_beta_shift = 8'h0c;
  localparam logic [7:0] off_gamma_mant = 8'h10;
  localparam logic [7:0] off_gamma_shift = 8'h14;
  localparam logic [7:0] off_delta_mant = 8'h18;
  localparam logic [7:0] off_delta_shift = 8'h1c;
  localparam logic [7:0] off_status = 8'h20;
  localparam logic [7:0] off_alpha_lo = 8'h24;
  localparam logic [7:0] off_alpha_hi = 8'h28;
  localparam logic [7:0] off_beta_lo = 8'h2c;
  localparam logic [7:0] off_beta_hi = 8'h30;
  localparam logic [7:0] off_gamma_lo = 8'h34;
  localparam logic [7:0] off_gamma_hi = 8'h38;
  localparam logic [7:0] off_delta_lo = 8'h3c;
  localparam logic [7:0] off_delta_hi = 8'h40;

  // Field widths.
  localparam int alpha_mant_w = 16;
  localparam int wide_mant_w = 17;
  localparam int delta_mant_w = 15;
  localparam int alpha_shift_w = 6;
  localparam int front_gain_w = 3;
  localparam int back_gain_w = 4;
  localparam int coeff_shift_w = 5;
  localparam int exp_w = 9;
  localparam int gain_w = 64;

  // Field positions inside the alpha exponent word.
  localparam int alpha_shift_lsb = 0;
  localparam int front_gain_lsb = 8;
  localparam int back_gain_lsb = 16;

  // Exponent offsets of each mantissa.
  localparam logic [8:0] alpha_base = 9'h010;
  localparam logic [8:0] beta_base = 9'h011;
  localparam logic [8:0] delta_base = 9'h00f;

  // Gains leave as signed fixed point with this many fraction bits.
  localparam logic [9:0] frac_bits = 10'h028;

  // Largest total alpha gain that the filter is meant to see.
  localparam logic [4:0] alpha_gain_limit = 5'h16;

  // Reset values.
  localparam logic [16:0] mant_reset = 17'h00001;
  localparam logic [5:0] shift_reset = 6'h00;

  // Status bit positions.
  localparam int st_alpha_zero = 0;
  localparam int st_beta_zero = 1;
  localparam int st_gamma_zero = 2;
  localparam int st_delta_zero = 3;
  localparam int st_gain_over = 4;

  typedef struct packed {
    logic [15:0] alpha_mant;
    logic [5:0] alpha_shift;
    logic [2:0] front_gain;
    logic [3:0] back_gain;
    logic [16:0] beta_mant;
    logic [4:0] beta_shift;
    logic [16:0] gamma_mant;
    logic [4:0] gamma_shift;
    logic [14:0] delta_mant;
    logic [4:0] delta_shift;
  } coeff_fields_type;

  typedef struct packed {
    logic signed [63:0] alpha;
    logic signed [63:0] beta;
    logic signed [63:0] gamma;
    logic signed [63:0] delta;
  } gains_type;

endpackage : coeff_pkg

// ===== coeff_scaler.sv
// Scales one mantissa by a power of two into signed fixed point.
// Assumes the exponent is already the full signed power of two.
`timescale 1ns/1ps
module coeff_scaler (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [16:0] mant,
  input wire logic signed [8:0] exponent,
  input wire logic negate,
  output logic signed [63:0] gain
);

  logic signed [9:0] point;
  logic [9:0] right;
  logic [63:0] mag;

  // Bits below the fraction field are dropped, so very small gains read as zero.
  always_comb begin
    point = 10'(exponent) + $signed(coeff_pkg::frac_bits);
    right = 10'(-point);
    if (!point[9]) begin
      mag = 64'(mant) << point[5:0];
    end else begin
      mag = 64'(mant) >> right;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gain <= '0;
    end else if (ce) begin
      gain <= negate ? -$signed(mag) : $signed(mag);
    end
  end

endmodule : coeff_scaler

// ===== apb_port.sv
// APB slave handshake with one wait state for every transfer.
// Assumes the owner decodes the address and supplies read data and a hit flag.
`timescale 1ns/1ps
module apb_port (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] local_rdata,
  input wire logic local_hit,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata
);

  // The answer is registered, which costs one wait state but keeps outputs on flops.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        pslverr <= !local_hit;
        prdata <= local_hit ? local_rdata : 32'h0000_0000;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

endmodule : apb_port

// ===== loop_filter_coeff_decode.sv
// Loop-filter coefficient decoder: field registers on APB and effective gains out.
// Assumes a single 25 MHz clock, synchronous APB inputs and software-quantized fields.
//
// Contract
// - Beta and gamma are stored as magnitudes and leave the block negated.
// - Alpha is its mantissa times two to the power of minus 16, minus shift, plus both gains.
// - The alpha shift (0 to 63) moves the point left; the two gain fields add gain.
// - Beta magnitude is its 17-bit mantissa times two to minus (17 plus a 0-31 shift).
// - Gamma magnitude is its 17-bit mantissa times two to minus (17 plus a 0-31 shift).
// - Delta is its 15-bit mantissa times two to minus (15 plus a 0-31 shift).
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module loop_filter_coeff_decode (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output coeff_pkg::gains_type gains,
  output logic [4:0] status
);

  coeff_pkg::coeff_fields_type fields;
  logic [31:0] local_rdata;
  logic local_hit;
  logic write_now;
  logic signed [8:0] alpha_exp;
  logic signed [8:0] beta_exp;
  logic signed [8:0] gamma_exp;
  logic signed [8:0] delta_exp;
  logic [4:0] next_status;

  function automatic logic signed [8:0] alpha_power(input logic [5:0] shift,
                                                     input logic [2:0] front,
                                                     input logic [3:0] back);
    alpha_power = 9'(front) + 9'(back) - 9'(shift) - coeff_pkg::alpha_base;
  endfunction : alpha_power

  function automatic logic signed [8:0] neg_power(input logic [8:0] base,
                                                   input logic [4:0] shift);
    neg_power = 9'h000 - base - 9'(shift);
  endfunction : neg_power

  function automatic logic [31:0] gain_word(input logic [63:0] value, input logic high);
    gain_word = high ? value[63:32] : value[31:0];
  endfunction : gain_word

  // Address decode and read data.
  always_comb begin
    local_hit = (paddr[1:0] == 2'h0) && (paddr[31:8] == 24'h000000);
    local_rdata = 32'h0000_0000;
    unique case (paddr[7:0])
      coeff_pkg::off_alpha_mant: local_rdata = 32'(fields.alpha_mant);
      coeff_pkg::off_alpha_exp: begin
        local_rdata[coeff_pkg::alpha_shift_lsb +: 6] = fields.alpha_shift;
        local_rdata[coeff_pkg::front_gain_lsb +: 3] = fields.front_gain;
        local_rdata[coeff_pkg::back_gain_lsb +: 4] = fields.back_gain;
      end
      coeff_pkg::off_beta_mant: local_rdata = 32'(fields.beta_mant);
      coeff_pkg::off_beta_shift: local_rdata = 32'(fields.beta_shift);
      coeff_pkg::off_gamma_mant: local_rdata = 32'(fields.gamma_mant);
      coeff_pkg::off_gamma_shift: local_rdata = 32'(fields.gamma_shift);
      coeff_pkg::off_delta_mant: local_rdata = 32'(fields.delta_mant);
      coeff_pkg::off_delta_shift: local_rdata = 32'(fields.delta_shift);
      coeff_pkg::off_status: local_rdata = 32'(status);
      coeff_pkg::off_alpha_lo: local_rdata = gain_word(gains.alpha, 1'b0);
      coeff_pkg::off_alpha_hi: local_rdata = gain_word(gains.alpha, 1'b1);
      coeff_pkg::off_beta_lo: local_rdata = gain_word(gains.beta, 1'b0);
      coeff_pkg::off_beta_hi: local_rdata = gain_word(gains.beta, 1'b1);
      coeff_pkg::off_gamma_lo: local_rdata = gain_word(gains.gamma, 1'b0);
      coeff_pkg::off_gamma_hi: local_rdata = gain_word(gains.gamma, 1'b1);
      coeff_pkg::off_delta_lo: local_rdata = gain_word(gains.delta, 1'b0);
      coeff_pkg::off_delta_hi: local_rdata = gain_word(gains.delta, 1'b1);
      default: local_hit = 1'b0;
    endcase
  end

  apb_port bus (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .local_rdata(local_rdata),
    .local_hit(local_hit),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata)
  );

  // A write lands at the edge where the slave's ready is sampled high.
  assign write_now = ce && psel && penable && pready && pwrite && local_hit;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fields.alpha_mant <= 16'(coeff_pkg::mant_reset);
      fields.alpha_shift <= coeff_pkg::shift_reset;
      fields.front_gain <= 3'(coeff_pkg::shift_reset);
      fields.back_gain <= 4'(coeff_pkg::shift_reset);
      fields.beta_mant <= coeff_pkg::mant_reset;
      fields.beta_shift <= 5'(coeff_pkg::shift_reset);
      fields.gamma_mant <= coeff_pkg::mant_reset;
      fields.gamma_shift <= 5'(coeff_pkg::shift_reset);
      fields.delta_mant <= 15'(coeff_pkg::mant_reset);
      fields.delta_shift <= 5'(coeff_pkg::shift_reset);
    end else if (write_now) begin
      unique case (paddr[7:0])
        coeff_pkg::off_alpha_mant: fields.alpha_mant <= pwdata[15:0];
        coeff_pkg::off_alpha_exp: begin
          fields.alpha_shift <= pwdata[coeff_pkg::alpha_shift_lsb +: 6];
          fields.front_gain <= pwdata[coeff_pkg::front_gain_lsb +: 3];
          fields.back_gain <= pwdata[coeff_pkg::back_gain_lsb +: 4];
        end
        coeff_pkg::off_beta_mant: fields.beta_mant <= pwdata[16:0];
        coeff_pkg::off_beta_shift: fields.beta_shift <= pwdata[4:0];
        coeff_pkg::off_gamma_mant: fields.gamma_mant <= pwdata[16:0];
        coeff_pkg::off_gamma_shift: fields.gamma_shift <= pwdata[4:0];
        coeff_pkg::off_delta_mant: fields.delta_mant <= pwdata[14:0];
        coeff_pkg::off_delta_shift: fields.delta_shift <= pwdata[4:0];
        default: ;
      endcase
    end
  end

  assign alpha_exp = alpha_power(fields.alpha_shift, fields.front_gain, fields.back_gain);
  assign beta_exp = neg_power(coeff_pkg::beta_base, fields.beta_shift);
  assign gamma_exp = neg_power(coeff_pkg::beta_base, fields.gamma_shift);
  assign delta_exp = neg_power(coeff_pkg::delta_base, fields.delta_shift);

  coeff_scaler alpha_scale (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .mant(17'(fields.alpha_mant)),
    .exponent(alpha_exp),
    .negate(1'b0),
    .gain(gains.alpha)
  );

  coeff_scaler beta_scale (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .mant(fields.beta_mant),
    .exponent(beta_exp),
    .negate(1'b1),
    .gain(gains.beta)
  );

  coeff_scaler gamma_scale (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .mant(fields.gamma_mant),
    .exponent(gamma_exp),
    .negate(1'b1),
    .gain(gains.gamma)
  );

  coeff_scaler delta_scale (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .mant(17'(fields.delta_mant)),
    .exponent(delta_exp),
    .negate(1'b0),
    .gain(gains.delta)
  );

  // Status only reports; the block still decodes whatever software wrote.
  always_comb begin
    next_status = '0;
    next_status[coeff_pkg::st_alpha_zero] = (fields.alpha_mant == 16'h0000);
    next_status[coeff_pkg::st_beta_zero] = (fields.beta_mant == 17'h00000);
    next_status[coeff_pkg::st_gamma_zero] = (fields.gamma_mant == 17'h00000);
    next_status[coeff_pkg::st_delta_zero] = (fields.delta_mant == 15'h0000);
    // gain limit flag
    // With these field widths the sum alone never passes the limit, so back gain taken
    // while the front gain is short of full is flagged as well.
    next_status[coeff_pkg::st_gain_over] =
      ((5'(fields.front_gain) + 5'(fields.back_gain)) > coeff_pkg::alpha_gain_limit)
      || ((fields.back_gain != 4'h0) && (fields.front_gain != '1));
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else if (ce) begin
      status <= next_status;
    end
  end

  property p_beta_negative;
    @(posedge clock) disable iff (!rst_n)
      ($past(ce) && $past(rst_n) && $stable(fields) && fields.beta_mant != 17'h00000
       && fields.beta_shift == 5'h00) |-> gains.beta < 0;
  endproperty
  a_beta_negative: assert property (p_beta_negative)
    else $error("beta gain not negative");

  property p_gamma_negative;
    @(posedge clock) disable iff (!rst_n)
      ($past(ce) && $past(rst_n) && $stable(fields) && fields.gamma_mant != 17'h00000
       && fields.gamma_shift == 5'h00) |-> gains.gamma < 0;
  endproperty
  a_gamma_negative: assert property (p_gamma_negative)
    else $error("gamma gain not negative");

  property p_alpha_unity;
    @(posedge clock) disable iff (!rst_n)
      ($past(ce) && $past(rst_n) && $stable(fields) && fields.alpha_shift == 6'h00
       && fields.front_gain == 3'h0 && fields.back_gain == 4'h0)
      |-> gains.alpha == 64'(fields.alpha_mant) << 24;
  endproperty
  a_alpha_unity: assert property (p_alpha_unity)
    else $error("alpha gain wrong at zero exponent fields");

  property p_alpha_gain;
    @(posedge clock) disable iff (!rst_n)
      ($past(ce) && $past(rst_n) && $stable(fields) && fields.alpha_shift == 6'h03
       && fields.front_gain == 3'h7 && fields.back_gain == 4'h2)
      |-> gains.alpha == 64'(fields.alpha_mant) << 30;
  endproperty
  a_alpha_gain: assert property (p_alpha_gain)
    else $error("alpha shift and gains combine wrongly");

  property p_beta_scale;
    @(posedge clock) disable iff (!rst_n)
      ($past(ce) && $past(rst_n) && $stable(fields) && fields.beta_shift == 5'h02)
      |-> gains.beta == -$signed(64'(fields.beta_mant) << 21);
  endproperty
  a_beta_scale: assert property (p_beta_scale)
    else $error("beta scaling wrong");

  property p_gamma_scale;
    @(posedge clock) disable iff (!rst_n)
      ($past(ce) && $past(rst_n) && $stable(fields) && fields.gamma_shift == 5'h17)
      |-> gains.gamma == -$signed(64'(fields.gamma_mant));
  endproperty
  a_gamma_scale: assert property (p_gamma_scale)
    else $error("gamma scaling wrong");

  property p_delta_scale;
    @(posedge clock) disable iff (!rst_n)
      ($past(ce) && $past(rst_n) && $stable(fields) && fields.delta_shift == 5'h01)
      |-> gains.delta == 64'(fields.delta_mant) << 24;
  endproperty
  a_delta_scale: assert property (p_delta_scale)
    else $error("delta scaling wrong");

  // Gains lag the fields by one edge, so every gain and status check waits for a settled field set.
  property p_gamma_unity;
    @(posedge clock) disable iff (!rst_n)
      ($past(ce) && $past(rst_n) && $stable(fields) && fields.gamma_shift == 5'h00)
      |-> gains.gamma == -$signed(64'(fields.gamma_mant) << 23);
  endproperty
  a_gamma_unity: assert property (p_gamma_unity)
    else $error("gamma scaling wrong at zero shift");

  property p_delta_unity;
    @(posedge clock) disable iff (!rst_n)
      ($past(ce) && $past(rst_n) && $stable(fields) && fields.delta_shift == 5'h00)
      |-> gains.delta == 64'(fields.delta_mant) << 25;
  endproperty
  a_delta_unity: assert property (p_delta_unity)
    else $error("delta scaling wrong at zero shift");

  property p_placement_flag;
    @(posedge clock) disable iff (!rst_n)
      ($past(ce) && $past(rst_n) && $stable(fields) && fields.back_gain != 4'h0
       && fields.front_gain != '1) |-> status[coeff_pkg::st_gain_over];
  endproperty
  a_placement_flag: assert property (p_placement_flag)
    else $error("misplaced alpha gain not flagged");

  property p_zero_flag;
    @(posedge clock) disable iff (!rst_n)
      ($past(ce) && $past(rst_n) && $stable(fields) && fields.beta_mant == 17'h00000)
      |-> status[coeff_pkg::st_beta_zero] && gains.beta == 64'sh0;
  endproperty
  a_zero_flag: assert property (p_zero_flag)
    else $error("zero beta mantissa not flagged or not zero gain");

  property p_answer_one_wait;
    @(posedge clock) disable iff (!rst_n)
      (ce && psel && penable && !pready) ##1 ce |-> pready;
  endproperty
  a_answer_one_wait: assert property (p_answer_one_wait)
    else $error("slave did not answer after one wait state");

  c_write: cover property (@(posedge clock) disable iff (!rst_n) write_now);
  c_error: cover property (@(posedge clock) disable iff (!rst_n) pslverr);
  c_gain_over: cover property (@(posedge clock) disable iff (!rst_n)
    status[coeff_pkg::st_gain_over]);
  c_read: cover property (@(posedge clock) disable iff (!rst_n)
    psel && penable && pready && !pwrite);
  c_frozen: cover property (@(posedge clock) disable iff (!rst_n) !ce);

endmodule : loop_filter_coeff_decode

// ===== loop_filter_coeff_decode_tb.sv
// Self-checking testbench for the loop-filter coefficient decoder.
// Assumes the decoder's own assertions are compiled with it; no partner model is needed.
`timescale 1ns/1ps
module loop_filter_coeff_decode_tb;
  logic clock;
  logic rst_n;
  logic ce;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  coeff_pkg::gains_type gains;
  logic [4:0] status;
  logic [31:0] rd;
  logic er;
  int n_errors;
  int cmp_count;

  loop_filter_coeff_decode dut_u (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .gains(gains),
    .status(status)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // Gain in Q24.40 from a mantissa and its net power of two plus 40, truncating below 2^-40.
  function automatic logic [63:0] scl(input logic [16:0] m, input int sh, input logic neg);
    logic [63:0] v;
    v = (sh >= 0) ? (64'(m) << sh) : (64'(m) >> (-sh));
    return neg ? (~v + 64'h1) : v;
  endfunction : scl

  // One APB transfer; the slave is expected to insert exactly one wait state.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      $display("Error at %0t: bus answer never came", $time);
      wrap_up();
    end
    chk(64'(i), 64'h1, "wait states");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
    chk(64'(er), 64'h0, "write error flag");
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h00000000, rd, er);
    chk(64'(rd), 64'(exp), "read data");
    chk(64'(er), 64'(exp_err), "read error flag");
  endtask : rdc

  task automatic settle;
    repeat (3) @(posedge clock);
  endtask : settle

  task automatic t_reset;
    chk(64'(status), 64'h0, "status after reset");
    chk(gains.alpha, scl(17'h00001, 24, 1'b0), "alpha reset");
    chk(gains.beta, scl(17'h00001, 23, 1'b1), "beta reset");
    chk(gains.gamma, scl(17'h00001, 23, 1'b1), "gamma reset");
    chk(gains.delta, scl(17'h00001, 25, 1'b0), "delta reset");
    rdc(coeff_pkg::off_alpha_mant, 32'h00000001, 1'b0);
    rdc(coeff_pkg::off_alpha_exp, 32'h00000000, 1'b0);
    rdc(coeff_pkg::off_alpha_lo, 32'h01000000, 1'b0);
    rdc(coeff_pkg::off_alpha_hi, 32'h00000000, 1'b0);
  endtask : t_reset

  task automatic t_example;
    logic [63:0] b;
    wr(coeff_pkg::off_alpha_mant, 32'h0000d0a8);
    wr(coeff_pkg::off_alpha_exp, 32'h00000006);
    wr(coeff_pkg::off_beta_mant, 32'h0001250b);
    wr(coeff_pkg::off_beta_shift, 32'h0000000d);
    wr(coeff_pkg::off_gamma_mant, 32'h00013abb);
    wr(coeff_pkg::off_gamma_shift, 32'h0000000d);
    wr(coeff_pkg::off_delta_mant, 32'h0000420a);
    wr(coeff_pkg::off_delta_shift, 32'h00000008);
    settle();
    b = scl(17'h1250b, 10, 1'b1);
    chk(gains.alpha, scl(17'h0d0a8, 18, 1'b0), "alpha example");
    chk(gains.beta, b, "beta example");
    chk(gains.gamma, scl(17'h13abb, 10, 1'b1), "gamma example");
    chk(gains.delta, scl(17'h0420a, 17, 1'b0), "delta example");
    rdc(coeff_pkg::off_beta_lo, b[31:0], 1'b0);
    rdc(coeff_pkg::off_beta_hi, b[63:32], 1'b0);
  endtask : t_example

  task automatic t_alpha_gain;
    wr(coeff_pkg::off_alpha_mant, 32'h00000001);
    // Seven steps in front, the excess of fifteen in back.
    wr(coeff_pkg::off_alpha_exp, 32'h000f0700);
    settle();
    chk(gains.alpha, scl(17'h00001, 46, 1'b0), "alpha full gain");
    chk(64'(status), 64'h0, "gain within limit");
    wr(coeff_pkg::off_alpha_mant, 32'h0000ffff);
    wr(coeff_pkg::off_alpha_exp, 32'h00000018);
    settle();
    chk(gains.alpha, scl(17'h0ffff, 0, 1'b0), "alpha shift 24");
    // Front gain is filled to seven before the back gain takes the rest.
    wr(coeff_pkg::off_alpha_exp, 32'h00020703);
    settle();
    chk(gains.alpha, scl(17'h0ffff, 30, 1'b0), "alpha shift with both gains");
    chk(64'(status), 64'h0, "front-first gain accepted");
    wr(coeff_pkg::off_alpha_exp, 32'h00020303);
    settle();
    chk(64'(status), 64'h10, "back gain before full front flagged");
    wr(coeff_pkg::off_alpha_exp, 32'hffffffff);
    rdc(coeff_pkg::off_alpha_exp, 32'h000f073f, 1'b0);
    settle();
    chk(gains.alpha, scl(17'h0ffff, -17, 1'b0), "alpha all fields max");
  endtask : t_alpha_gain

  task automatic t_limits;
    wr(coeff_pkg::off_beta_mant, 32'h0001ff00);
    wr(coeff_pkg::off_beta_shift, 32'h0000001f);
    wr(coeff_pkg::off_gamma_mant, 32'h0001ffff);
    wr(coeff_pkg::off_gamma_shift, 32'h00000000);
    wr(coeff_pkg::off_delta_mant, 32'h00007fc0);
    wr(coeff_pkg::off_delta_shift, 32'h0000001f);
    settle();
    chk(gains.beta, scl(17'h1ff00, -8, 1'b1), "beta max shift");
    chk(gains.gamma, scl(17'h1ffff, 23, 1'b1), "gamma max mantissa");
    chk(gains.delta, scl(17'h07fc0, -6, 1'b0), "delta max shift");
    rdc(coeff_pkg::off_delta_mant, 32'h00007fc0, 1'b0);
    wr(coeff_pkg::off_beta_shift, 32'h00000002);
    wr(coeff_pkg::off_gamma_shift, 32'h00000017);
    wr(coeff_pkg::off_delta_shift, 32'h00000001);
    settle();
    chk(gains.beta, scl(17'h1ff00, 21, 1'b1), "beta shift 2");
    chk(gains.gamma, scl(17'h1ffff, 0, 1'b1), "gamma shift 23");
    chk(gains.delta, scl(17'h07fc0, 24, 1'b0), "delta shift 1");
  endtask : t_limits

  // The field lands while the enable is still high; the scalers must then hold.
  task automatic t_freeze;
    wr(coeff_pkg::off_delta_shift, 32'h00000002);
    ce <= 1'b0;
    settle();
    chk(gains.delta, scl(17'h07fc0, 24, 1'b0), "gains frozen while ce low");
    ce <= 1'b1;
    settle();
    chk(gains.delta, scl(17'h07fc0, 23, 1'b0), "gains resume with ce");
  endtask : t_freeze

  task automatic t_errors;
    rdc(8'h44, 32'h00000000, 1'b1);
    rdc(8'h02, 32'h00000000, 1'b1);
    wr(coeff_pkg::off_status, 32'hffffffff);
    wr(coeff_pkg::off_beta_mant, 32'h00000000);
    settle();
    chk(64'(status), 64'h2, "beta zero flagged");
    chk(gains.beta, 64'h0, "beta zero gain");
    rdc(coeff_pkg::off_status, 32'h00000002, 1'b0);
    wr(coeff_pkg::off_gamma_mant, 32'h00000000);
    wr(coeff_pkg::off_delta_mant, 32'h00000000);
    wr(coeff_pkg::off_alpha_mant, 32'h00000000);
    settle();
    chk(64'(status), 64'hf, "all mantissas zero flagged");
    chk(gains.alpha, 64'h0, "alpha zero gain");
  endtask : t_errors

  initial begin
    n_errors = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    settle();
    t_reset();
    t_example();
    t_alpha_gain();
    t_limits();
    t_freeze();
    t_errors();
    wrap_up();
  end
endmodule : loop_filter_coeff_decode_tb
